// ---- rtl/sensor_port_pkg.sv ----
// Shared constants and carrier types for the sensor two-wire readout port
package sensor_port_pkg;

  // ----------------------------------------------------------------
  // Clock rates and derived timing counts
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_KHZ     = 25000;
  localparam int unsigned LINK_CLK_PS      = 12000;
  localparam int unsigned STARTUP_MS       = 10;
  localparam int unsigned STARTUP_CYC      = STARTUP_MS * CORE_CLK_KHZ;
  localparam int unsigned UPD_US_4M [4]    = '{500, 1500, 6500, 32000};
  localparam int unsigned UPD_US_1M [4]    = '{1600, 5000, 25000, 125000};
  localparam int unsigned BITRATE_FAST_KHZ = 400;
  localparam int unsigned BITRATE_STD_KHZ  = 100;
  localparam int unsigned FAST_PERIOD_NS   = 1000000 / BITRATE_FAST_KHZ;
  // SCL high shorter than a fast-mode period means the bus runs above standard rate
  localparam int unsigned STD_HIGH_MIN_CYC = (FAST_PERIOD_NS * 1000 + LINK_CLK_PS - 1) / LINK_CLK_PS;

  function automatic int unsigned us_to_cyc(input int unsigned us);
    return us * (CORE_CLK_KHZ / 1000);
  endfunction

  localparam int unsigned UPD_CYC_4M [4] = '{us_to_cyc(UPD_US_4M[0]), us_to_cyc(UPD_US_4M[1]),
                                            us_to_cyc(UPD_US_4M[2]), us_to_cyc(UPD_US_4M[3])};
  localparam int unsigned UPD_CYC_1M [4] = '{us_to_cyc(UPD_US_1M[0]), us_to_cyc(UPD_US_1M[1]),
                                            us_to_cyc(UPD_US_1M[2]), us_to_cyc(UPD_US_1M[3])};

  // ----------------------------------------------------------------
  // Data widths, correction scaling and status codes
  // ----------------------------------------------------------------
  localparam int unsigned PRES_W     = 14;
  localparam int unsigned TEMP_W     = 11;
  localparam int unsigned GAIN_SHIFT = 12;
  localparam int unsigned TC_SHIFT   = 8;
  localparam logic [13:0] PRES_MAX   = 14'h3fff;
  localparam logic [1:0]  STAT_VALID = 2'h0;
  localparam logic [1:0]  STAT_STALE = 2'h2;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       i2c_mode;
    logic       sleep_mode;
    logic       clk_1mhz;
    logic [1:0] update_rate;
    logic [6:0] slave_addr;
  } cfg_t;

  typedef struct packed {
    logic [15:0] gain;
    logic [15:0] offset;
    logic [7:0]  tcoef;
  } coef_t;

  typedef struct packed {
    logic [1:0]        status;
    logic [PRES_W-1:0] pres;
    logic [TEMP_W-1:0] temp;
  } result_t;

endpackage

// ---- rtl/sensor_two_wire_readout_port.sv ----
// Sensor digital core and two-wire readout port with its link-clock front end
`timescale 1ns/100ps

module sensor_two_wire_readout_port
#(
  parameter int unsigned STARTUP_CYCLES = sensor_port_pkg::STARTUP_CYC,
  parameter int unsigned UPD_4M [4]     = sensor_port_pkg::UPD_CYC_4M,
  parameter int unsigned UPD_1M [4]     = sensor_port_pkg::UPD_CYC_1M
)(
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic                    link_clk,
  input  wire sensor_port_pkg::cfg_t   cfg_strap,
  input  wire sensor_port_pkg::coef_t  coef_strap,
  output logic                         conv_start,
  input  wire logic                    conv_done,
  input  wire logic [13:0]             raw_pres,
  input  wire logic [10:0]             raw_temp,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  output logic                         int_out,
  output logic                         int_oe,
  output sensor_port_pkg::result_t     result
);
  import sensor_port_pkg::*;

  // ----------------------------------------------------------------
  // Correction arithmetic
  // ----------------------------------------------------------------
  function automatic logic [13:0] correct_pressure(input logic [13:0] raw, input logic [10:0] tmp, input coef_t c);
    logic signed [35:0] acc;
    logic signed [35:0] tc;
    acc = $signed({22'h0, raw}) * $signed({20'h0, c.gain});
    tc  = $signed({25'h0, tmp}) * $signed({{28{c.tcoef[7]}}, c.tcoef});
    acc = (acc >>> GAIN_SHIFT) + $signed({{20{c.offset[15]}}, c.offset}) + (tc >>> TC_SHIFT);
    if (acc < 0)
      return 14'h0000;
    else if (acc > $signed({22'h0, PRES_MAX}))
      return PRES_MAX;
    else
      return acc[13:0];
  endfunction

  function automatic logic [7:0] frame_byte(input result_t f, input logic [1:0] idx);
    if (idx == 2'h0)
      return {f.status, f.pres[13:8]};
    else if (idx == 2'h1)
      return f.pres[7:0];
    else if (idx == 2'h2)
      return f.temp[10:3];
    else
      return {f.temp[2:0], 5'h00};
  endfunction

  // First bit on the wire of a frame byte; sets the pull-down as the byte loads
  function automatic logic frame_msb(input result_t f, input logic [1:0] idx);
    logic [7:0] b;
    b = frame_byte(f, idx);
    return b[7];
  endfunction

  typedef enum logic [1:0] {C_BOOT = 2'b00, C_WAIT = 2'b01, C_CONV = 2'b10, C_CALC = 2'b11} core_state_t;
  typedef enum logic [2:0] {L_IDLE = 3'b000, L_ADDR = 3'b001, L_AACK = 3'b010, L_WDATA = 3'b011,
                            L_WACK = 3'b100, L_RDATA = 3'b101, L_RACK = 3'b110, L_SKIP = 3'b111} link_state_t;

  core_state_t  cstate;
  link_state_t  lstate;
  cfg_t         cfg_lock;
  coef_t        coef_lock;
  logic         locked;
  int unsigned  wait_cnt;
  int unsigned  period;
  logic [13:0]  pres_q;
  logic [10:0]  temp_q;
  logic [13:0]  calc_pres;
  logic         meas_pending;
  logic [2:0]   meas_sync;
  logic [2:0]   fetch_sync;
  logic         meas_evt;
  logic         fetch_evt;
  logic         dirty;
  logic         xfer_req;
  result_t      xfer_data;
  logic [1:0]   ack_sync;
  logic         launch;
  logic [1:0]   link_rst_sync;
  logic         link_rst;
  cfg_t         cfg_meta;
  cfg_t         cfg_link;
  logic [1:0]   req_sync;
  logic         req_seen;
  result_t      link_data;
  result_t      frame;
  logic [2:0]   scl_s;
  logic [2:0]   sda_s;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_cond;
  logic         stop_cond;
  logic         busy;
  logic [2:0]   bit_cnt;
  logic [7:0]   shreg;
  logic [1:0]   byte_idx;
  logic         phase;
  logic         acked;
  logic         poison;
  logic         no_clk;
  logic         meas_tog;
  logic         fetch_tog;
  logic [7:0]   high_cnt;
  logic         too_fast;

  // ----------------------------------------------------------------
  // Core domain: locked configuration and conversion sequencing
  // ----------------------------------------------------------------
  // Straps caught by a clocked process after release, frozen from then on
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      locked    <= 1'b0;
      cfg_lock  <= '0;
      coef_lock <= '0;
    end
    else if (!locked)
    begin
      locked    <= 1'b1;
      cfg_lock  <= cfg_strap;
      coef_lock <= coef_strap;
    end

  assign period    = cfg_lock.clk_1mhz ? UPD_1M[cfg_lock.update_rate] : UPD_4M[cfg_lock.update_rate];
  assign calc_pres = correct_pressure(pres_q, temp_q, coef_lock);
  assign meas_evt  = meas_sync[2] ^ meas_sync[1];
  assign fetch_evt = fetch_sync[2] ^ fetch_sync[1];

  // Event toggles from the link side; the second and third stages feed the edge detect
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      meas_sync  <= 3'h0;
      fetch_sync <= 3'h0;
      ack_sync   <= 2'h0;
    end
    else
    begin
      meas_sync  <= {meas_sync[1:0], meas_tog};
      fetch_sync <= {fetch_sync[1:0], fetch_tog};
      ack_sync   <= {ack_sync[0], req_seen};
    end

  // Conversion sequencer: startup wait, then periodic or requested conversions
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      cstate     <= C_BOOT;
      wait_cnt   <= 0;
      conv_start <= 1'b0;
      pres_q     <= 14'h0000;
      temp_q     <= 11'h000;
    end
    else
    begin
      conv_start <= 1'b0;
      case (cstate)
        C_BOOT:
          if (wait_cnt >= STARTUP_CYCLES - 1)
          begin
            cstate     <= C_CONV;
            conv_start <= 1'b1;
          end
          else
            wait_cnt <= wait_cnt + 1;
        C_WAIT:
          if (cfg_lock.sleep_mode ? (meas_pending || meas_evt) : (wait_cnt >= period - 1))
          begin
            cstate     <= C_CONV;
            conv_start <= 1'b1;
          end
          else
            wait_cnt <= wait_cnt + 1;
        C_CONV:
          if (conv_done)
          begin
            cstate <= C_CALC;
            pres_q <= raw_pres;
            temp_q <= raw_temp;
          end
        default:
        begin
          cstate   <= C_WAIT;
          wait_cnt <= 0;
        end
      endcase
    end

  // Requests arriving mid-conversion in sleep mode are held; a new request beats the clear
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
      meas_pending <= 1'b0;
    else if (meas_evt && cfg_lock.sleep_mode)
      meas_pending <= 1'b1;
    else if (conv_start)
      meas_pending <= 1'b0;

  // Output register and interrupt; a fresh result wins over a same-cycle fetch
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      result  <= '{status: STAT_STALE, pres: 14'h0000, temp: 11'h000};
      int_out <= 1'b0;
    end
    else if (cstate == C_CALC)
    begin
      result  <= '{status: STAT_VALID, pres: calc_pres, temp: temp_q};
      int_out <= cfg_lock.i2c_mode;
    end
    else if (fetch_evt)
    begin
      result.status <= STAT_STALE;
      int_out       <= 1'b0;
    end

  assign int_oe = cfg_lock.i2c_mode;
  assign launch = dirty && (xfer_req == ack_sync[1]);

  // Word handshake toward the link: data held stable while a request toggle is open
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      dirty     <= 1'b0;
      xfer_req  <= 1'b0;
      xfer_data <= '0;
    end
    else
    begin
      dirty <= (dirty && !launch) || (cstate == C_CALC) || fetch_evt;
      if (launch)
      begin
        xfer_req  <= ~xfer_req;
        xfer_data <= result;
      end
    end

  // ----------------------------------------------------------------
  // Link domain: reset release, pin synchronisers, snapshot capture
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk or posedge reset)
    if (reset)
      link_rst_sync <= 2'h3;
    else
      link_rst_sync <= {link_rst_sync[0], 1'b0};

  assign link_rst = link_rst_sync[1];

  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      scl_s     <= 3'h7;
      sda_s     <= 3'h7;
      cfg_meta  <= '0;
      cfg_link  <= '0;
      req_sync  <= 2'h0;
      req_seen  <= 1'b0;
      link_data <= '0;
    end
    else
    begin
      scl_s    <= {scl_s[1:0], scl_in};
      sda_s    <= {sda_s[1:0], sda_in};
      cfg_meta <= cfg_lock;
      cfg_link <= cfg_meta;
      req_sync <= {req_sync[0], xfer_req};
      if (req_sync[1] != req_seen)
      begin
        req_seen  <= req_sync[1];
        link_data <= xfer_data;
      end
    end

  assign scl_rise   = scl_s[1] && !scl_s[2];
  assign scl_fall   = !scl_s[1] && scl_s[2];
  assign start_cond = scl_s[1] && scl_s[2] && sda_s[2] && !sda_s[1];
  assign stop_cond  = scl_s[1] && scl_s[2] && !sda_s[2] && sda_s[1];
  assign busy       = (lstate != L_IDLE) && (lstate != L_SKIP);
  assign too_fast   = cfg_link.clk_1mhz && (high_cnt < 8'(STD_HIGH_MIN_CYC));
  assign sda_out    = 1'b0;

  // SCL high width, saturating, for the bus rate check
  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
      high_cnt <= 8'h00;
    else if (!scl_s[1])
      high_cnt <= 8'h00;
    else if (high_cnt != 8'hff)
      high_cnt <= high_cnt + 8'h01;

  // ----------------------------------------------------------------
  // Link domain: two-wire slave with the port's start/stop quirks
  // ----------------------------------------------------------------
  // Limitation: no clock stretching, so the master sees data as soon as it clocks
  always_ff @(posedge link_clk or posedge link_rst)
    if (link_rst)
    begin
      lstate    <= L_IDLE;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      byte_idx  <= 2'h0;
      phase     <= 1'b0;
      acked     <= 1'b0;
      poison    <= 1'b0;
      no_clk    <= 1'b0;
      sda_oe    <= 1'b0;
      meas_tog  <= 1'b0;
      fetch_tog <= 1'b0;
      frame     <= '0;
    end
    else if (start_cond)
    begin
      no_clk <= 1'b1;
      sda_oe <= 1'b0;
      // A second SDA fall after the first SCL rise lands here as a restart
      if (busy)
      begin
        poison <= 1'b1;
        lstate <= L_SKIP;
      end
      else if (poison)
      begin
        poison <= 1'b0;
        lstate <= L_SKIP;
      end
      else
      begin
        lstate  <= L_ADDR;
        bit_cnt <= 3'h0;
      end
    end
    else if (stop_cond)
    begin
      if (no_clk)
        poison <= 1'b1;
      lstate <= L_IDLE;
      sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      no_clk <= 1'b0;
      case (lstate)
        L_ADDR:
        begin
          shreg   <= {shreg[6:0], sda_s[1]};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7)
          begin
            phase <= 1'b0;
            if (cfg_link.i2c_mode && shreg[6:0] == cfg_link.slave_addr)
            begin
              lstate <= L_AACK;
              acked  <= sda_s[1];
            end
            else
              lstate <= L_SKIP;
          end
        end
        L_WDATA, L_RDATA:
        begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7)
          begin
            lstate <= (lstate == L_WDATA) ? L_WACK : L_RACK;
            phase  <= 1'b0;
          end
        end
        L_AACK, L_WACK:
          phase <= 1'b1;
        L_RACK:
        begin
          phase <= 1'b1;
          acked <= !sda_s[1];
        end
        default:
          lstate <= lstate;
      endcase
    end
    else if (scl_fall)
    begin
      if (busy && too_fast)
      begin
        lstate <= L_SKIP;
        sda_oe <= 1'b0;
      end
      else
        case (lstate)
          L_AACK, L_WACK:
            if (!phase)
              sda_oe <= 1'b1;
            else if (lstate == L_AACK && acked)
            begin
              lstate    <= L_RDATA;
              frame     <= link_data;
              fetch_tog <= ~fetch_tog;
              shreg     <= frame_byte(link_data, 2'h0);
              sda_oe    <= !frame_msb(link_data, 2'h0);
              byte_idx  <= 2'h1;
              bit_cnt   <= 3'h0;
            end
            else
            begin
              if (lstate == L_AACK)
                meas_tog <= ~meas_tog;
              lstate  <= L_WDATA;
              sda_oe  <= 1'b0;
              bit_cnt <= 3'h0;
            end
          L_RDATA:
          begin
            shreg  <= {shreg[6:0], 1'b0};
            sda_oe <= !shreg[6];
          end
          L_RACK:
            if (!phase)
              sda_oe <= 1'b0;
            else if (acked)
            begin
              lstate   <= L_RDATA;
              shreg    <= frame_byte(frame, byte_idx);
              sda_oe   <= !frame_msb(frame, byte_idx);
              byte_idx <= byte_idx + 2'h1;
              bit_cnt  <= 3'h0;
            end
            else
              lstate <= L_SKIP;
          default:
            sda_oe <= 1'b0;
        endcase
    end

  // ----------------------------------------------------------------
  // Assertions and covers
  // ----------------------------------------------------------------
  property p_sleep_no_conv;
    @(posedge core_clk) disable iff (reset)
      (cstate == C_WAIT && cfg_lock.sleep_mode && !meas_pending && !meas_evt) |=> !conv_start;
  endproperty
  a_sleep_no_conv: assert property (p_sleep_no_conv) else $error("conversion started in sleep without request");

  property p_cfg_frozen;
    @(posedge core_clk) disable iff (reset) locked |=> $stable(cfg_lock) && $stable(coef_lock);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("locked configuration changed");

  property p_result_written;
    @(posedge core_clk) disable iff (reset)
      cstate == C_CALC |=> result.pres == $past(calc_pres) && result.status == STAT_VALID;
  endproperty
  a_result_written: assert property (p_result_written) else $error("corrected result not stored valid");

  property p_stale_after_fetch;
    @(posedge core_clk) disable iff (reset)
      (fetch_evt && cstate != C_CALC) |=> result.status == STAT_STALE && !int_out;
  endproperty
  a_stale_after_fetch: assert property (p_stale_after_fetch) else $error("status not stale after fetch");

  property p_int_rise;
    @(posedge core_clk) disable iff (reset)
      (cstate == C_CALC && cfg_lock.i2c_mode) |=> int_out && int_oe;
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("interrupt not raised on new data");

  property p_startstop_poison;
    @(posedge link_clk) disable iff (link_rst) (stop_cond && no_clk && !start_cond) |=> poison;
  endproperty
  a_startstop_poison: assert property (p_startstop_poison) else $error("empty start-stop did not poison");

  property p_restart_poison;
    @(posedge link_clk) disable iff (link_rst) (start_cond && busy) |=> poison && lstate == L_SKIP;
  endproperty
  a_restart_poison: assert property (p_restart_poison) else $error("restart did not spoil transfer");

  property p_recover;
    @(posedge link_clk) disable iff (link_rst)
      (start_cond && !busy) |=> (lstate == (($past(poison)) ? L_SKIP : L_ADDR)) && !poison;
  endproperty
  a_recover: assert property (p_recover) else $error("start did not recover as expected");

  property p_addr_ack;
    @(posedge link_clk) disable iff (link_rst)
      (lstate == L_AACK && !phase && scl_fall && !too_fast && !start_cond && !stop_cond) |=> sda_oe;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  c_read: cover property (@(posedge link_clk) disable iff (link_rst) lstate == L_RACK ##1 lstate == L_RDATA);
  c_measure: cover property (@(posedge core_clk) disable iff (reset) meas_evt ##[1:4] conv_start);
  c_recovery: cover property (@(posedge link_clk) disable iff (link_rst) poison ##1 !poison);

endmodule // sensor_two_wire_readout_port

// ---- verification/sensor_two_wire_readout_port_bench.sv ----
// Testbench for the sensor readout port with conversion and bus partners
`timescale 1ns/100ps
module sensor_two_wire_readout_port_bench;
  import sensor_port_pkg::*;
  localparam int unsigned UPD [4] = '{50, 60, 70, 80};
  logic core_clk, link_clk, reset, conv_start, conv_done;
  logic sda_out, sda_oe, int_out, int_oe, scl_low, sda_low;
  logic [13:0] raw_pres, exp_pres;
  logic [10:0] raw_temp, exp_temp;
  logic [15:0] lfsr = 16'h0033;
  logic [15:0] r, q;
  logic [8:0]  rx;
  cfg_t        cfg, cfg_used;
  coef_t       coef, coef_used;
  result_t     result;
  int          miscompares = 0;
  int          checks = 0;
  int          convs = 0;
  int          n;
  wire scl = !scl_low;
  wire sda = !sda_low && !(sda_oe && !sda_out); // Pull-up unless pulled
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = !core_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = !link_clk;
  end
  sensor_two_wire_readout_port #(.STARTUP_CYCLES(20), .UPD_4M(UPD), .UPD_1M(UPD))
  sensor_two_wire_readout_port_i (.core_clk(core_clk), .reset(reset),
    .link_clk(link_clk), .cfg_strap(cfg), .coef_strap(coef),
    .conv_start(conv_start), .conv_done(conv_done), .raw_pres(raw_pres),
    .raw_temp(raw_temp), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe), .result(result));
  two_wire_master_model two_wire_master_model_i (.sda(sda), .scl_low(scl_low),
    .sda_low(sda_low));
  // ---------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // Gain, offset and temperature term, clipped to the output range
  function automatic logic [13:0] corr(logic [13:0] p, logic [10:0] t, coef_t c);
    int v;
    v = ((int'(p) * int'(c.gain)) >>> GAIN_SHIFT) + int'($signed(c.offset))
      + ((int'(t) * int'($signed(c.tcoef))) >>> TC_SHIFT);
    if (v < 0) return 14'h0000;
    if (v > int'(PRES_MAX)) return PRES_MAX;
    return v[13:0];
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic addr(input logic rd);
    two_wire_master_model_i.start_cond();
    two_wire_master_model_i.byte_io({cfg_used.slave_addr, rd, 1'b1}, rx);
  endtask
  task automatic fetch(input logic [1:0] st);
    logic [31:0] d;
    addr(1'b1);
    check(16'(rx[0]), 16'h0000);
    for (int i = 3; i >= 0; i--)
    begin
      two_wire_master_model_i.byte_io({8'hff, i == 0}, rx);
      d[i*8+:8] = rx[8:1];
    end
    two_wire_master_model_i.stop_cond();
    check(d[31:16], {st, exp_pres});
    check(d[15:0], {exp_temp, 5'h00});
  endtask
  // Bounded wait for fresh data, then the result register itself
  task automatic wait_int();
    for (int n = 0; n < 400 && int_out !== 1'b1; n++) @(posedge core_clk);
    #1 check(16'(int_out), 16'h0001);
    check(16'(result.pres), 16'(exp_pres));
  endtask
  task automatic results();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Conversion partner: random latency; data lines scramble when not valid
  always @(negedge core_clk)
    if (conv_start === 1'b1)
    begin
      convs++;
      q = rnd();
      repeat (q[2:0] + 3) @(posedge core_clk);
      q = rnd();
      #1 conv_done = 1'b1;
      raw_pres = q[13:0];
      raw_temp = q[15:5];
      exp_pres = corr(raw_pres, raw_temp, coef_used);
      exp_temp = raw_temp;
      @(posedge core_clk);
      #1 conv_done = 1'b0;
      raw_pres = ~raw_pres;
      raw_temp = ~raw_temp;
    end
  initial
  begin
    #3_000_000;
    miscompares++;
    results();
  end
  // ---------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    conv_done = 1'b0;
    raw_pres = 14'h0000;
    raw_temp = 11'h000;
    r = rnd();
    q = rnd();
    cfg = cfg_t'({3'b110, r[1:0], r[8:2]});
    coef = coef_t'({r, q, 1'b0, r[14:8]});
    cfg_used = cfg;
    coef_used = coef;
    repeat (4) @(posedge core_clk);
    check(16'({result.status, conv_start, int_out}), 16'({STAT_STALE, 2'b00}));
    #1 reset = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 cfg = cfg_t'(~cfg); // Straps move after capture; the port must not
    coef = coef_t'(~coef);
    wait_int();
    check(16'({result.status, int_oe}), 16'({STAT_VALID, 1'b1}));
    fetch(STAT_VALID);
    repeat (10) @(posedge core_clk);
    #1 check(16'({result.status, int_out}), 16'({STAT_STALE, 1'b0}));
    fetch(STAT_STALE);
    addr(1'b0);
    check(16'(rx[0]), 16'h0000);
    two_wire_master_model_i.stop_cond();
    wait_int();
    cfg_used.slave_addr ^= 7'h01;
    addr(1'b1);
    check(16'(rx[0]), 16'h0001);
    two_wire_master_model_i.stop_cond();
    cfg_used.slave_addr ^= 7'h01;
    two_wire_master_model_i.start_stop();
    addr(1'b1);
    check(16'(rx[0]), 16'h0001);
    two_wire_master_model_i.stop_cond();
    fetch(STAT_VALID);
    addr(1'b0);
    addr(1'b1);
    check(16'(rx[0]), 16'h0001);
    two_wire_master_model_i.stop_cond();
    addr(1'b1);
    check(16'(rx[0]), 16'h0001);
    two_wire_master_model_i.stop_cond();
    wait_int();
    fetch(STAT_VALID);
    // Second reset: update mode on the slow core strap
    @(posedge core_clk);
    #1 reset = 1'b1;
    cfg = cfg_t'({3'b101, r[3:2], cfg_used.slave_addr});
    coef = coef_used;
    cfg_used = cfg;
    repeat (4) @(posedge core_clk);
    check(16'({result.status, conv_start, int_out}), 16'({STAT_STALE, 2'b00}));
    #1 reset = 1'b0;
    wait_int();
    n = convs;
    repeat (200) @(posedge core_clk);
    check(16'(convs > n), 16'h0001);
    addr(1'b1);
    check(16'(rx[0]), 16'h0001);
    two_wire_master_model_i.stop_cond();
    results();
  end
endmodule // sensor_two_wire_readout_port_bench

// ---- verification/two_wire_master_model.sv ----
// Two-wire bus master model driving open-drain clock and data lines
`timescale 1ns/100ps
module two_wire_master_model #(
  parameter int unsigned Q_NS = 625 // Quarter bit: 400 kHz on a 4 MHz core
)(
  input  wire logic sda,
  output logic      scl_low,
  output logic      sda_low
);
  // Idle: both lines released to their pull-ups
  initial
  begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // -----------------------------------------------------------
  // Bus conditions; a quarter bit after each SCL fall keeps
  // SDA moves clear of the synchroniser window
  // -----------------------------------------------------------
  task automatic start_cond();
    #(Q_NS) sda_low = 1'b0;
    #(Q_NS) scl_low = 1'b0;
    #(Q_NS) sda_low = 1'b1;
    #(Q_NS) scl_low = 1'b1;
  endtask
  task automatic stop_cond();
    #(Q_NS) sda_low = 1'b1;
    #(Q_NS) scl_low = 1'b0;
    #(Q_NS) sda_low = 1'b0;
    #(4 * Q_NS); // Bus free time
  endtask
  // Start then stop with SCL left high throughout
  task automatic start_stop();
    sda_low = 1'b1;
    #(2 * Q_NS) sda_low = 1'b0;
    #(4 * Q_NS);
  endtask
  // Eight bits plus acknowledge; a one releases SDA
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      #(Q_NS) sda_low = !tx[i];
      #(Q_NS) scl_low = 1'b0;
      #(Q_NS) rx[i] = sda;
      #(Q_NS) scl_low = 1'b1;
    end
  endtask
endmodule // two_wire_master_model
